// [common/cpbb_defines.svh]
`ifndef CPBB_DEFINES_SVH
`define CPBB_DEFINES_SVH

`define CPBB_ADDR_W 32
`define CPBB_DATA_W 128
`define CPBB_FIFO_DEPTH 8
`define CPBB_FIFO_CNT_W 4
// one-hot grant codes
`define CPBB_GNT_NONE 3'h0
`define CPBB_GNT_EXT 3'h1
`define CPBB_GNT_DMA 3'h2
`define CPBB_GNT_BRIDGE 3'h4
`define CPBB_GNT_EXT_BIT 0
`define CPBB_GNT_DMA_BIT 1
`define CPBB_GNT_BRIDGE_BIT 2
// external port urgency: inbound depth above which it is urgent, write age in core cycles
`define CPBB_EXT_URG_DEPTH 4'h2
`define CPBB_EXT_WAIT_CYC 4'hA
// inbound high priority: entries incl. the one in service, lone wait in core cycles
`define CPBB_IB_HIGH_ENTRIES 4'h2
`define CPBB_IB_WAIT_CYC 5'h10
// addresses at or above this are registers, below are internal memory
`define CPBB_REG_BASE 32'h001E_0000

`endif

// [common/cpbb_pkg.sv]
package cpbb_pkg;
`include "cpbb_defines.svh"

  typedef enum logic [1:0] {
    ob_write = 2'h0,
    ob_read = 2'h1,
    ob_fetch = 2'h2
  } cpbb_ob_kind_t;

  typedef enum logic [1:0] {
    ib_return = 2'h0,
    ib_write = 2'h1,
    ib_read = 2'h2
  } cpbb_ib_kind_t;

  typedef enum logic [1:0] {
    ob_idle = 2'h0,
    ob_drive = 2'h1
  } cpbb_ob_state_t;

  typedef enum logic [1:0] {
    ib_idle = 2'h0,
    ib_req = 2'h1,
    ib_ret = 2'h3
  } cpbb_ib_state_t;

  typedef struct packed {
    cpbb_ob_kind_t kind;
    logic [`CPBB_ADDR_W-1:0] addr;
    logic [`CPBB_DATA_W-1:0] data;
  } cpbb_ob_entry_t;

  typedef struct packed {
    logic urgent;
    cpbb_ib_kind_t kind;
    logic [`CPBB_ADDR_W-1:0] addr;
    logic [`CPBB_DATA_W-1:0] data;
  } cpbb_ib_entry_t;

endpackage : cpbb_pkg

// [common/cpbb_fifo_if.sv]
`timescale 1ns/10ps
interface cpbb_fifo_if #(
  parameter int W = 8,
  parameter int CNT_W = 4
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic [CNT_W-1:0] count;

  modport fill (output wr_valid, output wr_data, input wr_ready);
  modport drain (input rd_valid, input rd_data, input count, output rd_ready);
  modport store (input wr_valid, input wr_data, input rd_ready,
                 output wr_ready, output rd_valid, output rd_data, output count);
endinterface : cpbb_fifo_if

// [design/cpbb_fifo.sv]
`timescale 1ns/10ps
module cpbb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // queue ports
  cpbb_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CNT_W-1:0] cnt_q;
  logic push;
  logic pop;

  assign q.wr_ready = cnt_q != CNT_W'(DEPTH);
  assign q.rd_valid = cnt_q != '0;
  assign q.rd_data = mem_q[rp_q];
  assign q.count = cnt_q;
  assign push = q.wr_valid & q.wr_ready;
  assign pop = q.rd_valid & q.rd_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= q.wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : AW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : AW'(rp_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= CNT_W'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CNT_W'(cnt_q - 1'b1);
      end
    end
  end
endmodule : cpbb_fifo

// [design/cpbb_bridge.sv]
// Contract
// - peripheral bus 128 bits, half core rate
// - only bridge, external port, DMA master
// - fixed priority: ext urgent, DMA urgent, bridge, ext, DMA
// - ext urgent when its queue holds over two
// - ext urgent after write waits 10 cycles
// - ext urgent while returning urgent DMA data
// - inbound transaction arbitrates again for memory
// - all transfers pass through queues and buffers
// - outbound queue takes J/K writes
// - outbound queue takes split core reads
// - outbound queue takes instruction bus fetches
// - inbound memory accesses run on memory bus
// - inbound register accesses run on K bus
// - core read returns delivered over K bus
// - read-return buffer carries master read data back
// - full outbound queue stalls core requests
// - inbound high priority: read, urgent, two entries
// - lone inbound raised high after 16 cycles
`timescale 1ns/10ps
`include "cpbb_defines.svh"
module cpbb_bridge (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // peripheral bus clock, sampled
  input wire logic peripheral_bus_clock,
  // J/K data bus requests
  input wire logic jk_req_valid,
  input wire logic jk_req_write,
  input wire logic [`CPBB_ADDR_W-1:0] jk_req_addr,
  input wire logic [`CPBB_DATA_W-1:0] jk_req_data,
  output logic jk_req_ready,
  // instruction bus fetches
  input wire logic i_req_valid,
  input wire logic [`CPBB_ADDR_W-1:0] i_req_addr,
  output logic i_req_ready,
  // peripheral bus arbitration
  input wire logic ext_req,
  input wire logic ext_req_write,
  input wire logic [`CPBB_FIFO_CNT_W-1:0] ext_iq_count,
  input wire logic ext_dma_urgent,
  input wire logic dma_req,
  input wire logic dma_urgent,
  output logic gnt_ext,
  output logic gnt_dma,
  output logic gnt_bridge,
  // peripheral bus, bridge as master
  output logic pb_out_valid,
  output cpbb_pkg::cpbb_ob_kind_t pb_out_kind,
  output logic [`CPBB_ADDR_W-1:0] pb_out_addr,
  output logic [`CPBB_DATA_W-1:0] pb_out_data,
  // peripheral bus, bridge as target
  input wire logic pb_in_valid,
  input wire logic pb_in_return,
  input wire logic pb_in_write,
  input wire logic pb_in_urgent,
  input wire logic [`CPBB_ADDR_W-1:0] pb_in_addr,
  input wire logic [`CPBB_DATA_W-1:0] pb_in_data,
  output logic pb_in_ready,
  output logic pb_rd_valid,
  output logic [`CPBB_DATA_W-1:0] pb_rd_data,
  // K bus
  output logic k_req_valid,
  output logic k_req_write,
  output logic [`CPBB_ADDR_W-1:0] k_req_addr,
  output logic [`CPBB_DATA_W-1:0] k_req_data,
  input wire logic k_gnt,
  input wire logic k_rvalid,
  input wire logic [`CPBB_DATA_W-1:0] k_rdata,
  // S (internal memory) bus
  output logic s_req_valid,
  output logic s_req_high,
  output logic s_req_write,
  output logic [`CPBB_ADDR_W-1:0] s_req_addr,
  output logic [`CPBB_DATA_W-1:0] s_req_data,
  input wire logic s_gnt,
  input wire logic s_rvalid,
  input wire logic [`CPBB_DATA_W-1:0] s_rdata
);
  import cpbb_pkg::*;

  localparam int SW = 14 + `CPBB_ADDR_W + `CPBB_DATA_W;

  function automatic logic [2:0] cpbb_pick(input logic eu, input logic du, input logic br,
                                           input logic en, input logic dn);
    if (eu) begin
      return `CPBB_GNT_EXT;
    end else if (du) begin
      return `CPBB_GNT_DMA;
    end else if (br) begin
      return `CPBB_GNT_BRIDGE;
    end else if (en) begin
      return `CPBB_GNT_EXT;
    end else if (dn) begin
      return `CPBB_GNT_DMA;
    end
    return `CPBB_GNT_NONE;
  endfunction : cpbb_pick

  function automatic logic cpbb_is_mem(input logic [`CPBB_ADDR_W-1:0] a);
    return a < `CPBB_REG_BASE;
  endfunction : cpbb_is_mem

  // reset release
  logic rst_m_q;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_sync_n <= rst_m_q;
    end
  end

  // every input from the peripheral side passes two flops; bus data is stable for a
  // whole peripheral cycle, which is why a plain two-flop stage is safe for the words
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {peripheral_bus_clock, ext_req, ext_req_write, ext_iq_count, ext_dma_urgent,
                  dma_req, dma_urgent, pb_in_valid, pb_in_return, pb_in_write, pb_in_urgent,
                  pb_in_addr, pb_in_data};
      sync2_q <= sync1_q;
    end
  end

  logic pb_clk_s;
  logic ext_req_s;
  logic ext_req_write_s;
  logic [`CPBB_FIFO_CNT_W-1:0] ext_iq_count_s;
  logic ext_dma_urgent_s;
  logic dma_req_s;
  logic dma_urgent_s;
  logic pb_in_valid_s;
  logic pb_in_return_s;
  logic pb_in_write_s;
  logic pb_in_urgent_s;
  logic [`CPBB_ADDR_W-1:0] pb_in_addr_s;
  logic [`CPBB_DATA_W-1:0] pb_in_data_s;
  assign {pb_clk_s, ext_req_s, ext_req_write_s, ext_iq_count_s, ext_dma_urgent_s, dma_req_s,
          dma_urgent_s, pb_in_valid_s, pb_in_return_s, pb_in_write_s, pb_in_urgent_s,
          pb_in_addr_s, pb_in_data_s} = sync2_q;

  // peripheral bus edge: grants, outbound drive, inbound capture and the return-buffer clear happen once per peripheral cycle
  logic pb_clk_d_q;
  logic pb_rise;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pb_clk_d_q <= 1'b0;
    end else begin
      pb_clk_d_q <= pb_clk_s;
    end
  end
  assign pb_rise = pb_clk_s & ~pb_clk_d_q;

  // queues
  cpbb_fifo_if #(.W($bits(cpbb_ob_entry_t)), .CNT_W(`CPBB_FIFO_CNT_W)) ob_q ();
  cpbb_fifo_if #(.W($bits(cpbb_ib_entry_t)), .CNT_W(`CPBB_FIFO_CNT_W)) ib_q ();

  cpbb_fifo #(.W($bits(cpbb_ob_entry_t)), .DEPTH(`CPBB_FIFO_DEPTH),
              .CNT_W(`CPBB_FIFO_CNT_W)) u_outbound_queue (
    .clock(clock),
    .rst_n(rst_sync_n),
    .q(ob_q)
  );

  cpbb_fifo #(.W($bits(cpbb_ib_entry_t)), .DEPTH(`CPBB_FIFO_DEPTH),
              .CNT_W(`CPBB_FIFO_CNT_W)) u_inbound_queue (
    .clock(clock),
    .rst_n(rst_sync_n),
    .q(ib_q)
  );

  // core side into the outbound queue; J/K has precedence over fetches
  cpbb_ob_entry_t ob_in;
  always_comb begin
    ob_in.kind = jk_req_write ? ob_write : ob_read;
    ob_in.addr = jk_req_addr;
    ob_in.data = jk_req_data;
    if (!jk_req_valid) begin
      ob_in.kind = ob_fetch;
      ob_in.addr = i_req_addr;
      ob_in.data = '0;
    end
  end
  assign ob_q.wr_valid = jk_req_valid | i_req_valid;
  assign ob_q.wr_data = ob_in;
  assign jk_req_ready = ob_q.wr_ready;
  assign i_req_ready = ob_q.wr_ready & ~jk_req_valid;

  // external port urgency
  logic [3:0] ext_wait_q;
  logic ext_urgent;
  logic [2:0] gnt_q;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_wait_q <= 4'h0;
    end else if (ext_req_s && ext_req_write_s && !gnt_q[`CPBB_GNT_EXT_BIT]) begin
      if (ext_wait_q != `CPBB_EXT_WAIT_CYC) begin
        ext_wait_q <= 4'(ext_wait_q + 4'h1);
      end
    end else begin
      ext_wait_q <= 4'h0;
    end
  end
  assign ext_urgent = (ext_iq_count_s > `CPBB_EXT_URG_DEPTH)
                    | (ext_wait_q == `CPBB_EXT_WAIT_CYC)
                    | ext_dma_urgent_s;

  // arbiter: one grant per peripheral cycle, decided at its edge
  cpbb_ob_state_t ob_state_q;
  logic bridge_req;
  logic [2:0] win;
  assign bridge_req = ob_q.rd_valid & (ob_state_q == ob_idle);
  assign win = cpbb_pick(ext_req_s & ext_urgent, dma_req_s & dma_urgent_s, bridge_req,
                         ext_req_s, dma_req_s);
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gnt_q <= `CPBB_GNT_NONE;
    end else if (pb_rise) begin
      gnt_q <= win;
    end
  end
  assign gnt_ext = gnt_q[`CPBB_GNT_EXT_BIT];
  assign gnt_dma = gnt_q[`CPBB_GNT_DMA_BIT];
  assign gnt_bridge = gnt_q[`CPBB_GNT_BRIDGE_BIT];

  // outbound drive: one peripheral cycle per transaction, popped when it ends
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ob_state_q <= ob_idle;
    end else if (pb_rise) begin
      case (ob_state_q)
        ob_idle: begin
          if (win == `CPBB_GNT_BRIDGE) begin
            ob_state_q <= ob_drive;
          end
        end
        ob_drive: begin
          ob_state_q <= ob_idle;
        end
        default: begin
          ob_state_q <= ob_idle;
        end
      endcase
    end
  end
  assign ob_q.rd_ready = pb_rise & (ob_state_q == ob_drive);

  cpbb_ob_entry_t ob_head;
  assign ob_head = ob_q.rd_data;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pb_out_valid <= 1'b0;
      pb_out_kind <= ob_write;
      pb_out_addr <= '0;
      pb_out_data <= '0;
    end else if (pb_rise) begin
      pb_out_valid <= (ob_state_q == ob_idle) && (win == `CPBB_GNT_BRIDGE);
      if (ob_state_q == ob_idle) begin
        pb_out_kind <= ob_head.kind;
        pb_out_addr <= ob_head.addr;
        pb_out_data <= ob_head.data;
      end
    end
  end

  // peripheral side into the inbound queue
  cpbb_ib_entry_t ib_in;
  always_comb begin
    ib_in.urgent = pb_in_urgent_s;
    ib_in.kind = pb_in_return_s ? ib_return : (pb_in_write_s ? ib_write : ib_read);
    ib_in.addr = pb_in_addr_s;
    ib_in.data = pb_in_data_s;
  end
  assign ib_q.wr_valid = pb_rise & pb_in_valid_s;
  assign ib_q.wr_data = ib_in;
  assign pb_in_ready = ib_q.wr_ready;

  // inbound service: pop, then arbitrate for the target bus
  cpbb_ib_state_t ib_state_q;
  cpbb_ib_entry_t cur_q;
  logic on_s_q;
  logic rr_valid_q;
  logic bus_gnt;
  logic ret_valid;
  logic [`CPBB_DATA_W-1:0] ret_data;
  cpbb_ib_entry_t ib_head;
  assign ib_head = ib_q.rd_data;
  assign bus_gnt = on_s_q ? s_gnt : k_gnt;
  assign ret_valid = on_s_q ? s_rvalid : k_rvalid;
  assign ret_data = on_s_q ? s_rdata : k_rdata;
  assign ib_q.rd_ready = (ib_state_q == ib_idle) & ~rr_valid_q;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ib_state_q <= ib_idle;
    end else begin
      case (ib_state_q)
        ib_idle: begin
          if (ib_q.rd_valid && !rr_valid_q) begin
            ib_state_q <= ib_req;
          end
        end
        ib_req: begin
          if (bus_gnt) begin
            ib_state_q <= (cur_q.kind == ib_read) ? ib_ret : ib_idle;
          end
        end
        ib_ret: begin
          if (ret_valid) begin
            ib_state_q <= ib_idle;
          end
        end
        default: begin
          ib_state_q <= ib_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur_q <= '0;
      on_s_q <= 1'b0;
    end else if (ib_q.rd_valid && ib_q.rd_ready) begin
      cur_q <= ib_head;
      // returns always go to a core register; master accesses split by address
      on_s_q <= (ib_head.kind != ib_return) && cpbb_is_mem(ib_head.addr);
    end
  end

  // lone-entry age for memory bus priority
  logic [4:0] ib_wait_q;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ib_wait_q <= 5'h00;
    end else if (ib_state_q == ib_req && !bus_gnt) begin
      if (ib_wait_q != `CPBB_IB_WAIT_CYC) begin
        ib_wait_q <= 5'(ib_wait_q + 5'h01);
      end
    end else begin
      ib_wait_q <= 5'h00;
    end
  end

  assign k_req_valid = (ib_state_q == ib_req) & ~on_s_q;
  assign k_req_write = cur_q.kind != ib_read;
  assign k_req_addr = cur_q.addr;
  assign k_req_data = cur_q.data;
  assign s_req_valid = (ib_state_q == ib_req) & on_s_q;
  assign s_req_write = cur_q.kind != ib_read;
  assign s_req_addr = cur_q.addr;
  assign s_req_data = cur_q.data;
  assign s_req_high = (cur_q.kind == ib_read) | cur_q.urgent
                    | (4'(ib_q.count + 4'h1) >= `CPBB_IB_HIGH_ENTRIES)
                    | (ib_wait_q == `CPBB_IB_WAIT_CYC);

  // read-return buffer, offered until the next peripheral edge; a fill beats the clear
  logic [`CPBB_DATA_W-1:0] rr_data_q;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rr_valid_q <= 1'b0;
      rr_data_q <= '0;
    end else if (ib_state_q == ib_ret && ret_valid) begin
      rr_valid_q <= 1'b1;
      rr_data_q <= ret_data;
    end else if (pb_rise) begin
      rr_valid_q <= 1'b0;
    end
  end
  assign pb_rd_valid = rr_valid_q;
  assign pb_rd_data = rr_data_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  sequence bridge_win_s;
    pb_rise && ob_state_q == ob_idle && win == `CPBB_GNT_BRIDGE;
  endsequence
  sequence ret_data_s;
    ib_state_q == ib_ret && ret_valid;
  endsequence

  gnt_onehot_a: assert property ($onehot0(gnt_q))
    else $error("more than one peripheral bus grant");
  ext_urgent_first_a: assert property (
    pb_rise && ext_req_s && ext_urgent |=> gnt_q == `CPBB_GNT_EXT)
    else $error("urgent external port not granted");
  dma_over_bridge_a: assert property (
    pb_rise && dma_req_s && dma_urgent_s && !(ext_req_s && ext_urgent)
    |=> gnt_q == `CPBB_GNT_DMA)
    else $error("urgent dma lost to lower priority");
  iq_depth_urgent_a: assert property (
    pb_rise && ext_req_s && ext_iq_count_s > `CPBB_EXT_URG_DEPTH |=> gnt_q == `CPBB_GNT_EXT)
    else $error("deep external queue not urgent");
  write_age_a: assert property (
    ext_req_s && ext_req_write_s && !gnt_ext [*8] ##1
    ext_req_s && ext_req_write_s && !gnt_ext ##1
    ext_req_s && ext_req_write_s && !gnt_ext |=> ext_urgent)
    else $error("aged external write not urgent");
  ob_full_stall_a: assert property (
    ob_q.count == 4'(`CPBB_FIFO_DEPTH) |-> !jk_req_ready && !i_req_ready)
    else $error("full outbound queue accepted a request");
  bridge_drive_a: assert property (bridge_win_s |=> pb_out_valid [*2])
    else $error("bridge transaction not driven after grant");
  s_read_high_a: assert property (
    s_req_valid && !s_req_write |-> s_req_high)
    else $error("memory read not high priority");
  lone_age_a: assert property (
    s_req_valid && !s_gnt [*8] ##1 s_req_valid && !s_gnt [*8] |=> !s_req_valid || s_req_high)
    else $error("aged inbound not raised");
  rr_fill_a: assert property (
    ret_data_s |=> rr_valid_q && rr_data_q == $past(ret_data))
    else $error("read data not held in return buffer");
endmodule : cpbb_bridge

// [dv/cpbb_bus_model.sv]
`timescale 1ns/10ps
module cpbb_bus_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // internal bus request
  input wire logic req_valid,
  input wire logic req_high,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [127:0] req_data,
  input wire logic [7:0] dly,
  // answer
  output logic gnt,
  output logic rvalid,
  output logic [127:0] rdata,
  // last transfer taken
  output logic [3:0] done_cnt,
  output logic last_high,
  output logic last_write,
  output logic [31:0] last_addr,
  output logic [127:0] last_data
);
  logic [7:0] wait_q;
  logic [1:0] rd_q;
  logic [127:0] pat_q;
  // the grant delay stands in for contention on the memory block
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 8'h00;
      gnt <= 1'b0;
    end else begin
      gnt <= req_valid && !gnt && (wait_q >= dly);
      wait_q <= (req_valid && !gnt) ? wait_q + 8'h01 : 8'h00;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {done_cnt, last_high, last_write, last_addr, last_data, rd_q} <= '0;
      pat_q <= 128'h0;
    end else begin
      pat_q <= ~pat_q;
      rd_q <= {rd_q[0], req_valid && gnt && !req_write};
      if (req_valid && gnt) begin
        done_cnt <= done_cnt + 4'h1;
        {last_high, last_write, last_addr, last_data} <= {req_high, req_write, req_addr, req_data};
      end
    end
  end
  // outside the answer cycle the data lines toggle, so stale data never matches
  assign rvalid = rd_q[1];
  assign rdata = rvalid ? {4{last_addr}} : pat_q;
endmodule : cpbb_bus_model

// [dv/cpbb_bridge_tb_top.sv]
`timescale 1ns/10ps
`include "cpbb_defines.svh"
module cpbb_bridge_tb_top;
  import cpbb_pkg::*;
  logic clock, rst_n, peripheral_bus_clock, pb_run;
  logic jk_req_valid, jk_req_write, jk_req_ready, i_req_valid, i_req_ready;
  logic [31:0] jk_req_addr, i_req_addr, pb_out_addr, pb_in_addr, k_req_addr, s_req_addr;
  logic [127:0] jk_req_data, pb_out_data, pb_in_data, pb_rd_data, k_req_data, k_rdata;
  logic [127:0] s_req_data, s_rdata, k_last_data, s_last_data;
  logic ext_req, ext_req_write, ext_dma_urgent, dma_req, dma_urgent, gnt_ext, gnt_dma;
  logic gnt_bridge, pb_out_valid, pb_in_valid, pb_in_return, pb_in_write, pb_in_urgent;
  logic pb_in_ready, pb_rd_valid, k_req_valid, k_req_write, k_gnt, k_rvalid;
  logic s_req_valid, s_req_high, s_req_write, s_gnt, s_rvalid;
  logic k_last_high, k_last_write, s_last_high, s_last_write;
  logic [3:0] ext_iq_count, k_done, s_done;
  logic [31:0] k_last_addr, s_last_addr;
  logic [7:0] dly;
  cpbb_ob_kind_t pb_out_kind;
  int error_cnt, check_count;

  cpbb_bridge u_cpbb_bridge (.clock, .rst_n, .peripheral_bus_clock, .jk_req_valid, .jk_req_write,
    .jk_req_addr, .jk_req_data, .jk_req_ready, .i_req_valid, .i_req_addr, .i_req_ready, .ext_req,
    .ext_req_write, .ext_iq_count, .ext_dma_urgent, .dma_req, .dma_urgent, .gnt_ext, .gnt_dma,
    .gnt_bridge, .pb_out_valid, .pb_out_kind, .pb_out_addr, .pb_out_data, .pb_in_valid,
    .pb_in_return, .pb_in_write, .pb_in_urgent, .pb_in_addr, .pb_in_data, .pb_in_ready,
    .pb_rd_valid, .pb_rd_data, .k_req_valid, .k_req_write, .k_req_addr, .k_req_data, .k_gnt,
    .k_rvalid, .k_rdata, .s_req_valid, .s_req_high, .s_req_write, .s_req_addr, .s_req_data,
    .s_gnt, .s_rvalid, .s_rdata);
  cpbb_bus_model u_cpbb_bus_model_k (.clock, .rst_n, .req_valid(k_req_valid), .req_high(1'b0),
    .req_write(k_req_write), .req_addr(k_req_addr), .req_data(k_req_data), .dly, .gnt(k_gnt),
    .rvalid(k_rvalid), .rdata(k_rdata), .done_cnt(k_done), .last_high(k_last_high),
    .last_write(k_last_write), .last_addr(k_last_addr), .last_data(k_last_data));
  cpbb_bus_model u_cpbb_bus_model_s (.clock, .rst_n, .req_valid(s_req_valid),
    .req_high(s_req_high), .req_write(s_req_write), .req_addr(s_req_addr),
    .req_data(s_req_data), .dly, .gnt(s_gnt), .rvalid(s_rvalid), .rdata(s_rdata),
    .done_cnt(s_done), .last_high(s_last_high), .last_write(s_last_write),
    .last_addr(s_last_addr), .last_data(s_last_data));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // link clock freezes while pb_run is low, as a stalled far side would
  initial begin
    peripheral_bus_clock = 1'b0;
    #7;
    forever begin
      #160;
      if (pb_run) peripheral_bus_clock = ~peripheral_bus_clock;
    end
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic push(input cpbb_ob_kind_t kd, input logic [31:0] a, input logic [127:0] d);
    int n;
    @(posedge clock);
    if (kd == ob_fetch) {i_req_valid, i_req_addr} <= {1'b1, a};
    else {jk_req_valid, jk_req_write, jk_req_addr, jk_req_data} <= {1'b1, kd == ob_write, a, d};
    for (n = 0; n < 200; n++) begin
      @(negedge clock);
      if (jk_req_valid ? jk_req_ready : i_req_ready) break;
    end
    @(posedge clock);
    {jk_req_valid, i_req_valid} <= 2'b00;
  endtask : push

  task automatic t_outbound();
    int i, n;
    logic [31:0] a;
    pb_run = 1'b0;
    for (i = 0; i < 8; i++) begin
      a = 32'h0020_0000 + 32'(i);
      push(cpbb_ob_kind_t'(i % 3), a, {~a, a, a, ~a});
    end
    @(negedge clock);
    check(jk_req_ready, 1'b0);
    check(i_req_ready, 1'b0);
    pb_run = 1'b1;
    for (i = 0; i < 8; i++) begin
      a = 32'h0020_0000 + 32'(i);
      for (n = 0; n < 100 && pb_out_valid !== 1'b1; n++) @(negedge clock);
      check(pb_out_kind, i % 3);
      check(pb_out_addr, a);
      if (i % 3 == 0) check(pb_out_data, {~a, a, a, ~a});
      for (n = 0; n < 100 && pb_out_valid !== 1'b0; n++) @(negedge clock);
    end
  endtask : t_outbound

  task automatic arb_idle();
    int n;
    @(posedge clock);
    {ext_req, ext_req_write, ext_iq_count, ext_dma_urgent, dma_req, dma_urgent} <= '0;
    for (n = 0; n < 100 && {gnt_bridge, gnt_dma, gnt_ext} !== 3'h0; n++) @(negedge clock);
  endtask : arb_idle

  // the loser keeps its request up until it is granted
  task automatic arb(input logic [3:0] cnt, input logic eu, du, input logic [2:0] e1, e2);
    int n;
    pb_run = 1'b0;
    @(posedge clock);
    {ext_req, ext_iq_count, ext_dma_urgent, dma_req, dma_urgent} <= {1'b1, cnt, eu, 1'b1, du};
    repeat (4) @(posedge clock);
    pb_run = 1'b1;
    for (n = 0; n < 100 && {gnt_bridge, gnt_dma, gnt_ext} === 3'h0; n++) @(negedge clock);
    check({gnt_bridge, gnt_dma, gnt_ext}, e1);
    @(posedge clock);
    if (e1 == `CPBB_GNT_EXT) ext_req <= 1'b0;
    if (e1 == `CPBB_GNT_DMA) dma_req <= 1'b0;
    for (n = 0; n < 100 && ({gnt_bridge, gnt_dma, gnt_ext} === e1 ||
         {gnt_bridge, gnt_dma, gnt_ext} === 3'h0); n++) @(negedge clock);
    check({gnt_bridge, gnt_dma, gnt_ext}, e2);
    arb_idle();
  endtask : arb

  task automatic t_arb();
    int n;
    arb(4'h0, 1'b0, 1'b0, `CPBB_GNT_EXT, `CPBB_GNT_DMA);
    arb(4'h0, 1'b0, 1'b1, `CPBB_GNT_DMA, `CPBB_GNT_EXT);
    arb(4'h3, 1'b0, 1'b1, `CPBB_GNT_EXT, `CPBB_GNT_DMA);
    arb(4'h2, 1'b0, 1'b1, `CPBB_GNT_DMA, `CPBB_GNT_EXT);
    arb(4'h0, 1'b1, 1'b1, `CPBB_GNT_EXT, `CPBB_GNT_DMA);
    pb_run = 1'b0;
    push(ob_write, 32'h0030_0000, 128'h0);
    arb(4'h0, 1'b0, 1'b0, `CPBB_GNT_BRIDGE, `CPBB_GNT_EXT);
    // a waiting write must overtake an urgent dma that keeps asking
    @(posedge clock);
    {ext_req, ext_req_write, dma_req, dma_urgent} <= 4'b1111;
    for (n = 0; n < 60 && gnt_ext !== 1'b1; n++) @(negedge clock);
    check(gnt_ext, 1'b1);
    arb_idle();
  endtask : t_arb

  task automatic ib(input logic ret, wr, urg, input logic [31:0] a, input logic [7:0] dl,
                    input logic sb, hi);
    int n;
    logic [3:0] k0, s0;
    logic [127:0] d;
    d = {a, ~a, ~a, a};
    k0 = k_done;
    s0 = s_done;
    @(negedge peripheral_bus_clock);
    @(posedge clock);
    dly <= dl;
    {pb_in_valid, pb_in_return, pb_in_write, pb_in_urgent} <= {1'b1, ret, wr, urg};
    {pb_in_addr, pb_in_data} <= {a, d};
    repeat (8) @(posedge clock);
    {pb_in_valid, pb_in_addr, pb_in_data} <= {1'b0, ~a, ~d};
    for (n = 0; n < 100 && (sb ? s_done : k_done) === (sb ? s0 : k0); n++) @(negedge clock);
    check(pb_in_ready, 1'b1);
    check(sb ? s_done : k_done, (sb ? s0 : k0) + 4'h1);
    check(sb ? k_done : s_done, sb ? k0 : s0);
    check(sb ? s_last_addr : k_last_addr, a);
    check(sb ? s_last_write : k_last_write, ret | wr);
    check(sb ? s_last_high : k_last_high, hi);
    if (ret | wr) check(sb ? s_last_data : k_last_data, d);
    else begin
      for (n = 0; n < 100 && pb_rd_valid !== 1'b1; n++) @(negedge clock);
      check(pb_rd_valid, 1'b1);
      check(pb_rd_data, {4{a}});
    end
  endtask : ib

  task automatic t_inbound();
    ib(1'b0, 1'b1, 1'b0, 32'h001D_FFFF, 8'h02, 1'b1, 1'b0);
    ib(1'b0, 1'b1, 1'b1, 32'h0000_1000, 8'h02, 1'b1, 1'b1);
    ib(1'b0, 1'b1, 1'b0, 32'h001E_0000, 8'h02, 1'b0, 1'b0);
    ib(1'b1, 1'b0, 1'b0, 32'h0010_0000, 8'h02, 1'b0, 1'b0);
    ib(1'b0, 1'b0, 1'b0, 32'h0000_2000, 8'h03, 1'b1, 1'b1);
    ib(1'b0, 1'b0, 1'b0, 32'h001E_0040, 8'h03, 1'b0, 1'b0);
    ib(1'b0, 1'b1, 1'b0, 32'h0000_3000, 8'h14, 1'b1, 1'b1);
  endtask : t_inbound

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    {rst_n, error_cnt, check_count, dly} = '0;
    pb_run = 1'b1;
    {jk_req_valid, jk_req_write, jk_req_addr, jk_req_data, i_req_valid, i_req_addr} = '0;
    {ext_req, ext_req_write, ext_iq_count, ext_dma_urgent, dma_req, dma_urgent} = '0;
    {pb_in_valid, pb_in_return, pb_in_write, pb_in_urgent, pb_in_addr, pb_in_data} = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    t_outbound();
    t_arb();
    t_inbound();
    tally_and_finish();
  end
  // the whole run needs under a thousand cycles
  initial begin
    #800000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : cpbb_bridge_tb_top
